//--- rtl/qsfl_fault_logic.sv
// Summary of operation
// - Off channel below threshold flags open load
// - Open load report waits masking interval
// - Four masking timers, restart on falling input
// - Any input high suppresses open-load report
// - Open-load fault needs others low, mask expired
// - Over-current detected only while channel commanded on
// - Over-current reported after sense interval, else nothing
// - Persistent over-current faults and switches channel off
// - Sense timers restart on each channel turn-on
// - Reported over-current restarts shared refresh timer
// - Refresh end retries faulted channels repeatedly
// - All channel faults ORed onto fault line
// - Fault line active low
// - Select picks single or paired input control
`timescale 1ns/1ps
`default_nettype none
`include "qsfl_regs.svh"

module qsfl_fault_logic #(
    parameter int NCH = `QSFL_CHANNELS,
    parameter int OFF_MASK_CYC = `QSFL_OFF_MASK_CYC,
    parameter int OC_SENSE_CYC = `QSFL_OC_SENSE_CYC,
    parameter int RETRY_OFF_CYC = `QSFL_RETRY_OFF_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] ctrl_in,
    input wire logic pair12_in,
    input wire logic pair34_in,
    input wire logic pair_sel,
    input wire logic [3:0] off_open_below,
    input wire logic [3:0] overcurrent_above,
    output logic [3:0] gate_on,
    output logic fault_n
);
    import qsfl_pkg::*;

    // =========================================
    // Input selection
    wire [3:0] pair_cmd = {pair34_in, pair34_in, pair12_in, pair12_in};
    wire [3:0] cmd = pair_sel ? pair_cmd : ctrl_in;
    wire any_cmd = |cmd;

    // =========================================
    // Shared refresh timer
    logic [3:0] oc_report;
    logic retry_running;
    logic retry_done;
    wire retry_restart = |oc_report;

    qsfl_retry_timer #(
        .RETRY_CYC(RETRY_OFF_CYC)
    ) u_retry (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .restart(retry_restart),
        .running(retry_running),
        .done(retry_done)
    );

    // =========================================
    // Per-channel logic
    logic [3:0] open_fault;
    logic [3:0] oc_fault_r;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ch
            qsfl_ch_state_t st_r;
            qsfl_ch_state_t st_nxt;
            logic [15:0] sense_r;
            logic [15:0] sense_nxt;
            logic mask_expired;

            qsfl_off_mask #(
                .MASK_CYC(OFF_MASK_CYC)
            ) u_mask (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .ch_on(cmd[g]),
                .expired(mask_expired)
            );

            // Open load: off, below threshold, mask over, all inputs low
            assign open_fault[g] = ~cmd[g] & off_open_below[g]
                & mask_expired & ~any_cmd;

            wire oc_seen = cmd[g] & overcurrent_above[g];
            wire sense_end = (sense_r == OC_SENSE_CYC[15:0] - 16'h0001);
            assign oc_report[g] = (st_r == QSFL_CH_SENSE) & sense_end & oc_seen;

            always_comb begin
                st_nxt = st_r;
                sense_nxt = sense_r;
                case (st_r)
                    QSFL_CH_OFF: begin
                        sense_nxt = 16'h0000;
                        if (cmd[g]) begin
                            st_nxt = QSFL_CH_SENSE;
                        end
                    end
                    QSFL_CH_SENSE: begin
                        if (!cmd[g]) begin
                            st_nxt = QSFL_CH_OFF;
                        end else if (oc_report[g]) begin
                            st_nxt = QSFL_CH_RETRY;
                            sense_nxt = 16'h0000;
                        end else if (!sense_end) begin
                            sense_nxt = sense_r + 16'h0001;
                        end
                    end
                    QSFL_CH_RETRY: begin
                        sense_nxt = 16'h0000;
                        if (!cmd[g]) begin
                            st_nxt = QSFL_CH_OFF;
                        end else if (retry_done) begin
                            st_nxt = QSFL_CH_SENSE;
                        end
                    end
                    default: begin
                        st_nxt = QSFL_CH_OFF;
                        sense_nxt = 16'h0000;
                    end
                endcase
            end

            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    st_r <= QSFL_CH_OFF;
                    sense_r <= 16'h0000;
                end else begin
                    st_r <= st_nxt;
                    sense_r <= sense_nxt;
                end
            end

            // Over-current flag held through retry, cleared on input low or clean sense
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    oc_fault_r[g] <= 1'b0;
                end else if (oc_report[g]) begin
                    oc_fault_r[g] <= 1'b1;
                end else if (!cmd[g]) begin
                    oc_fault_r[g] <= 1'b0;
                end else if ((st_r == QSFL_CH_SENSE) & sense_end & ~overcurrent_above[g]) begin
                    oc_fault_r[g] <= 1'b0;
                end
            end

            // Gate off while waiting out the refresh interval
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    gate_on[g] <= 1'b0;
                end else begin
                    gate_on[g] <= cmd[g] & (st_nxt != QSFL_CH_RETRY);
                end
            end
        end
    endgenerate

    // =========================================
    // Fault output
    wire any_fault = (|open_fault) | (|oc_fault_r);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_n <= 1'b1;
        end else begin
            fault_n <= ~any_fault;
        end
    end

    logic unused_retry;
    assign unused_retry = retry_running;
endmodule
`default_nettype wire

//--- rtl/qsfl_regs.svh
`ifndef QSFL_REGS_SVH
`define QSFL_REGS_SVH

// Timing figures as nominal values
`define QSFL_CLK_HZ 20000000
`define QSFL_OFF_MASK_NS 19000
`define QSFL_OC_SENSE_NS 55000
`define QSFL_RETRY_OFF_NS 3600000

// Cycle counts derived from the figures at the core clock rate
`define QSFL_OFF_MASK_CYC ((`QSFL_OFF_MASK_NS * (`QSFL_CLK_HZ / 1000000)) / 1000)
`define QSFL_OC_SENSE_CYC ((`QSFL_OC_SENSE_NS * (`QSFL_CLK_HZ / 1000000)) / 1000)
`define QSFL_RETRY_OFF_CYC ((`QSFL_RETRY_OFF_NS * (`QSFL_CLK_HZ / 1000000)) / 1000)

`define QSFL_CHANNELS 4

`endif

//--- rtl/qsfl_pkg.sv
package qsfl_pkg;
    typedef enum logic [1:0] {
        QSFL_CH_OFF = 2'b00,
        QSFL_CH_SENSE = 2'b01,
        QSFL_CH_RETRY = 2'b10
    } qsfl_ch_state_t;
endpackage

//--- rtl/qsfl_off_mask.sv
`timescale 1ns/1ps
`default_nettype none
`include "qsfl_regs.svh"

module qsfl_off_mask #(
    parameter int MASK_CYC = `QSFL_OFF_MASK_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ch_on,
    output logic expired
);
    import qsfl_pkg::*;

    logic [15:0] cnt_r;
    logic ch_on_r;
    wire fall = ch_on_r & ~ch_on;
    wire done = (cnt_r == MASK_CYC[15:0]);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 16'h0000;
            ch_on_r <= 1'b0;
        end else begin
            ch_on_r <= ch_on;
            if (ch_on || fall) begin
                cnt_r <= 16'h0000;
            end else if (!done) begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    assign expired = done & ~ch_on;
endmodule
`default_nettype wire

//--- rtl/qsfl_retry_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "qsfl_regs.svh"

module qsfl_retry_timer #(
    parameter int RETRY_CYC = `QSFL_RETRY_OFF_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic restart,
    output logic running,
    output logic done
);
    import qsfl_pkg::*;

    logic [23:0] cnt_r;
    logic run_r;
    wire last = (cnt_r == RETRY_CYC[23:0] - 24'h000001);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 24'h000000;
            run_r <= 1'b0;
        end else if (restart) begin
            cnt_r <= 24'h000000;
            run_r <= 1'b1;
        end else if (run_r) begin
            cnt_r <= cnt_r + 24'h000001;
            if (last) begin
                run_r <= 1'b0;
            end
        end
    end

    assign running = run_r;
    assign done = run_r & last & ~restart;
endmodule
`default_nettype wire

//--- tb/qsfl_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Port checks
module qsfl_checker #(
    parameter int RETRY_OFF_CYC = 64
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] ctrl_in,
    input wire logic pair12_in,
    input wire logic pair34_in,
    input wire logic pair_sel,
    input wire logic [3:0] off_open_below,
    input wire logic [3:0] overcurrent_above,
    input wire logic [3:0] gate_on,
    input wire logic fault_n
);
    wire logic [3:0] eff;
    wire logic oc0;
    logic [7:0] off_cnt_r;
    assign eff = pair_sel ? {pair34_in, pair34_in, pair12_in, pair12_in} : ctrl_in;
    assign oc0 = eff[0] && overcurrent_above[0];
    // Cycles channel 0 is commanded but held off
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            off_cnt_r <= 8'h00;
        end else begin
            off_cnt_r <= (eff[0] && !gate_on[0]) ? off_cnt_r + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_ol_wait;
        (eff == 4'h0 && off_open_below != 4'h0) [*8];
    endsequence
    sequence s_oc_hold;
        oc0 [*8];
    endsequence
    property p_gate_off;
        1'b1 |=> (gate_on & ~$past(eff)) == 4'h0;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("gate on uncommanded");
    property p_idle_high;
        (eff == 4'h0 && off_open_below == 4'h0) [*3] |-> fault_n;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("fault idle low");
    property p_ol_supp;
        eff != 4'h0 && fault_n && (eff & overcurrent_above) == 4'h0 |=> fault_n;
    endproperty
    a_ol_supp: assert property (p_ol_supp) else $error("open load not hidden");
    property p_ol_mask;
        $fell(eff[1]) && eff == 4'h0 && fault_n |=> fault_n [*8];
    endproperty
    a_ol_mask: assert property (p_ol_mask) else $error("open load early");
    property p_ol_report;
        s_ol_wait ##1 s_ol_wait |-> !fault_n;
    endproperty
    a_ol_report: assert property (p_ol_report) else $error("open load lost");
    property p_oc_report;
        s_oc_hold ##1 s_oc_hold ##1 s_oc_hold |-> !fault_n;
    endproperty
    a_oc_report: assert property (p_oc_report) else $error("overcurrent lost");
    property p_oc_cut;
        $fell(fault_n) && oc0 |-> !gate_on[0];
    endproperty
    a_oc_cut: assert property (p_oc_cut) else $error("channel not cut");
    property p_retry_max;
        off_cnt_r <= RETRY_OFF_CYC + 4;
    endproperty
    a_retry_max: assert property (p_retry_max) else $error("no retry");
    property p_retry_min;
        $rose(gate_on[0]) |-> off_cnt_r <= 8'h02 || off_cnt_r >= RETRY_OFF_CYC - 4;
    endproperty
    a_retry_min: assert property (p_retry_min) else $error("retry early");
endmodule

bind qsfl_fault_logic qsfl_checker #(.RETRY_OFF_CYC(RETRY_OFF_CYC)) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .ctrl_in(ctrl_in), .pair12_in(pair12_in),
    .pair34_in(pair34_in), .pair_sel(pair_sel), .off_open_below(off_open_below),
    .overcurrent_above(overcurrent_above), .gate_on(gate_on), .fault_n(fault_n));
`default_nettype wire

//--- tb/qsfl_load_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Loads and comparators
module qsfl_load_model (
    input wire logic [3:0] gate_on,
    input wire logic [3:0] open_ld,
    input wire logic [3:0] short_ld,
    output logic [3:0] off_open_below,
    output logic [3:0] overcurrent_above
);
    // Off output is pulled up unless the load is open
    assign off_open_below = ~gate_on & open_ld;
    assign overcurrent_above = (~gate_on & ~open_ld) | (gate_on & short_ld);
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Bench
module tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] ctrl_in = 4'h0;
    logic pair12_in = 1'b0;
    logic pair34_in = 1'b0;
    logic pair_sel = 1'b0;
    logic [3:0] open_ld = 4'h0;
    logic [3:0] short_ld = 4'h0;
    wire logic [3:0] below;
    wire logic [3:0] above;
    wire logic [3:0] gate_on;
    wire logic fault_n;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    int k;
    always #25 core_clk = ~core_clk;
    qsfl_fault_logic #(.OFF_MASK_CYC(8), .OC_SENSE_CYC(16), .RETRY_OFF_CYC(64)) u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .ctrl_in(ctrl_in), .pair12_in(pair12_in),
        .pair34_in(pair34_in), .pair_sel(pair_sel), .off_open_below(below),
        .overcurrent_above(above), .gate_on(gate_on), .fault_n(fault_n));
    qsfl_load_model u_load (.gate_on(gate_on), .open_ld(open_ld), .short_ld(short_ld),
        .off_open_below(below), .overcurrent_above(above));
    task automatic end_sim();
        if (n_fail == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 2000) begin
            n_fail++;
            end_sim();
        end
    end
    task automatic t_sel();
        {pair34_in, pair12_in} = 2'h3;
        for (k = 0; k < 4; k++) begin
            ctrl_in = 4'h1 << k;
            tick(2);
            chk(gate_on, 4'h1 << k);
        end
        pair_sel = 1'b1;
        ctrl_in = 4'hF;
        for (k = 0; k < 4; k++) begin
            {pair34_in, pair12_in} = k[1:0];
            tick(2);
            chk(gate_on, {k[1], k[1], k[0], k[0]});
        end
        pair_sel = 1'b0;
        ctrl_in = 4'h0;
        tick(3);
    endtask
    task automatic t_open();
        open_ld = 4'h2;
        ctrl_in = 4'h2;
        tick(3);
        ctrl_in = 4'h0;
        tick(6);
        chk(fault_n, 1'b1);
        tick(6);
        chk(fault_n, 1'b0);
        ctrl_in = 4'h4;
        tick(2);
        chk(fault_n, 1'b1);
        ctrl_in = 4'h0;
        tick(3);
        chk(fault_n, 1'b0);
        tick(16);
        chk(fault_n, 1'b0);
        open_ld = 4'h0;
        tick(3);
        chk(fault_n, 1'b1);
    endtask
    task automatic t_oc();
        short_ld = 4'h1;
        ctrl_in = 4'h1;
        tick(8);
        short_ld = 4'h0;
        tick(20);
        chk(fault_n, 1'b1);
        ctrl_in = 4'h0;
        tick(2);
        short_ld = 4'h1;
        ctrl_in = 4'h3;
        for (k = 0; fault_n === 1'b1 && k < 40; k++) begin
            tick(1);
        end
        chk(k >= 15 && k <= 21, 1'b1);
        chk(gate_on, 4'h2);
        for (k = 0; gate_on[0] === 1'b0 && k < 100; k++) begin
            tick(1);
        end
        chk(k >= 60 && k <= 68, 1'b1);
        chk(fault_n, 1'b0);
        for (k = 0; gate_on[0] === 1'b1 && k < 40; k++) begin
            tick(1);
        end
        chk(k >= 14 && k <= 20, 1'b1);
        short_ld = 4'h0;
        for (k = 0; gate_on[0] === 1'b0 && k < 100; k++) begin
            tick(1);
        end
        tick(24);
        chk({gate_on, fault_n}, 5'h07);
        ctrl_in = 4'h0;
        tick(3);
    endtask
    initial begin
        tick(10);
        rst_n = 1'b1;
        tick(2);
        t_sel();
        t_open();
        t_oc();
        end_sim();
    end
endmodule
`default_nettype wire
